// [logic/gpd_pins.sv]
// Purpose: Default functions, reset strap and software override of the general pins
// Assumes: Software control arrives as plain level inputs; clk_125_src is a free clock
// Notes: Output enables are active low; pins stay undriven until the second enabled clock edge after reset
`timescale 1ns/1ps
`default_nettype none
module gpd_pins (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic link_up,
	input wire logic carrier_sense,
	input wire logic clk_125_src,
	input wire gpd_pkg::gpd_par_t par_mode,
	input wire gpd_pkg::gpd_func_t first_out_func,
	input wire gpd_pkg::gpd_func_t second_out_func,
	input wire gpd_pkg::gpd_func_t bidir_one_func,
	input wire gpd_pkg::gpd_func_t bidir_two_func,
	input wire gpd_pkg::gpd_func_t bidir_three_func,
	input wire gpd_pkg::gpd_func_t bidir_four_func,
	input wire gpd_pkg::gpd_func_t bidir_five_func,
	input wire gpd_pkg::gpd_func_t bidir_six_func,
	input wire gpd_pkg::gpd_func_t bidir_seven_func,
	input wire logic first_general_output_i,
	output logic first_general_output_o,
	output logic first_general_output_oe_n,
	input wire logic second_general_output_i,
	output logic second_general_output_o,
	output logic second_general_output_oe_n,
	input wire logic bidir_pin_one_i,
	output logic bidir_pin_one_o,
	output logic bidir_pin_one_oe_n,
	input wire logic bidir_pin_two_i,
	output logic bidir_pin_two_o,
	output logic bidir_pin_two_oe_n,
	input wire logic bidir_pin_three_i,
	output logic bidir_pin_three_o,
	output logic bidir_pin_three_oe_n,
	input wire logic bidir_pin_four_shared_i,
	output logic bidir_pin_four_shared_o,
	output logic bidir_pin_four_shared_oe_n,
	input wire logic bidir_pin_five_shared_i,
	output logic bidir_pin_five_shared_o,
	output logic bidir_pin_five_shared_oe_n,
	input wire logic bidir_pin_six_shared_i,
	output logic bidir_pin_six_shared_o,
	output logic bidir_pin_six_shared_oe_n,
	input wire logic bidir_pin_seven_shared_i,
	output logic bidir_pin_seven_shared_o,
	output logic bidir_pin_seven_shared_oe_n,
	output logic [gpd_pkg::GPD_NUM_GPO-1:0] gpo_in_level,
	output logic [gpd_pkg::GPD_NUM_BIDIR-1:0] bidir_in_level,
	output logic [gpd_pkg::GPD_SHARED_NUM-1:0] txd_upper,
	output logic strap_clk_out
);
	import gpd_pkg::*;

	gpd_state_t st;
	gpd_state_t next_st;
	gpd_func_t bfn [GPD_NUM_BIDIR];
	logic [GPD_NUM_PINS-1:0] pin_in;
	logic gmii;

	// Returns {level, oe_n} for a pin given its selected function
	function automatic logic [1:0] pin_drive(input gpd_func_t fn, input logic dflt_o,
			input logic dflt_oe_n);
		logic [1:0] r;
		r = 2'h1;
		case (fn)
			GPD_FN_DEFAULT: r = {dflt_o, dflt_oe_n};
			GPD_FN_INPUT: r = 2'h1;
			GPD_FN_LOW: r = 2'h0;
			GPD_FN_HIGH: r = 2'h2;
			default: r = 2'h1;
		endcase
		return r;
	endfunction

	// Unpacked so each entry keeps its enum type; entry 0 is pin one
	assign bfn = '{bidir_one_func, bidir_two_func, bidir_three_func,
		bidir_four_func, bidir_five_func, bidir_six_func,
		bidir_seven_func};
	assign pin_in = {bidir_pin_seven_shared_i, bidir_pin_six_shared_i, bidir_pin_five_shared_i,
		bidir_pin_four_shared_i, bidir_pin_three_i, bidir_pin_two_i, bidir_pin_one_i,
		second_general_output_i, first_general_output_i};
	assign gmii = (par_mode == GPD_PAR_GMII);

	always_comb begin
		logic [1:0] dv;
		dv = 2'h1;
		next_st = st;
		// First stage feeds only the second stage
		next_st.sync_a = pin_in;
		next_st.sync_b = st.sync_a;
		if (!st.strap_done) begin
			// Outputs still undriven here, so the board level is what gets caught
			next_st.strap_done = 1'b1;
			next_st.strap_clk = first_general_output_i;
		end else begin
			dv = pin_drive(first_out_func, link_up, 1'b0);
			next_st.gpo_o[GPD_SYNC_GPO_FIRST] = dv[1];
			next_st.gpo_oe_n[GPD_SYNC_GPO_FIRST] = dv[0];
			dv = pin_drive(second_out_func, carrier_sense, 1'b0);
			next_st.gpo_o[GPD_SYNC_GPO_SECOND] = dv[1];
			next_st.gpo_oe_n[GPD_SYNC_GPO_SECOND] = dv[0];
			// Strap decides whether pin one defaults to clock out or stays undriven
			dv = pin_drive(bfn[0], 1'b0, !st.strap_clk);
			next_st.clk_sel = st.strap_clk && (bfn[0] == GPD_FN_DEFAULT);
			next_st.bd_o[0] = dv[1];
			next_st.bd_oe_n[0] = dv[0];
			for (int i = 1; i < GPD_NUM_BIDIR; i++) begin
				dv = pin_drive(bfn[i], 1'b0, 1'b1);
				// In GMII the shared pins carry transmit data into the device
				if (i >= GPD_SHARED_LO && gmii) begin
					dv = 2'h1;
				end
				next_st.bd_o[i] = dv[1];
				next_st.bd_oe_n[i] = dv[0];
			end
		end
		for (int j = 0; j < GPD_SHARED_NUM; j++) begin
			next_st.txd_hi[j] = gmii ? st.sync_b[GPD_SYNC_BIDIR_BASE + GPD_SHARED_LO + j]
				: 1'b0;
		end
	end

	// Enable low holds every flop, so pins keep their last drive while frozen, except pin one, which still passes clk_125_src while clk_sel is set
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st <= GPD_ST_RESET;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign first_general_output_o = st.gpo_o[GPD_SYNC_GPO_FIRST];
	assign first_general_output_oe_n = st.gpo_oe_n[GPD_SYNC_GPO_FIRST];
	assign second_general_output_o = st.gpo_o[GPD_SYNC_GPO_SECOND];
	assign second_general_output_oe_n = st.gpo_oe_n[GPD_SYNC_GPO_SECOND];
	// Clock cannot be regenerated from a 50 MHz flop, so it is muxed straight through
	assign bidir_pin_one_o = st.clk_sel ? clk_125_src : st.bd_o[0];
	assign bidir_pin_one_oe_n = st.bd_oe_n[0];
	assign bidir_pin_two_o = st.bd_o[1];
	assign bidir_pin_two_oe_n = st.bd_oe_n[1];
	assign bidir_pin_three_o = st.bd_o[2];
	assign bidir_pin_three_oe_n = st.bd_oe_n[2];
	assign bidir_pin_four_shared_o = st.bd_o[3];
	assign bidir_pin_four_shared_oe_n = st.bd_oe_n[3];
	assign bidir_pin_five_shared_o = st.bd_o[4];
	assign bidir_pin_five_shared_oe_n = st.bd_oe_n[4];
	assign bidir_pin_six_shared_o = st.bd_o[5];
	assign bidir_pin_six_shared_oe_n = st.bd_oe_n[5];
	assign bidir_pin_seven_shared_o = st.bd_o[6];
	assign bidir_pin_seven_shared_oe_n = st.bd_oe_n[6];
	assign gpo_in_level = st.sync_b[GPD_NUM_GPO-1:0];
	assign bidir_in_level = st.sync_b[GPD_NUM_PINS-1:GPD_SYNC_BIDIR_BASE];
	assign txd_upper = st.txd_hi;
	assign strap_clk_out = st.strap_clk;

	link_default_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && st.strap_done && first_out_func == GPD_FN_DEFAULT |=>
		first_general_output_o == $past(link_up) && !first_general_output_oe_n)
		else $error("first general output does not follow link status");

	crs_default_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && st.strap_done && second_out_func == GPD_FN_DEFAULT |=>
		second_general_output_o == $past(carrier_sense) && !second_general_output_oe_n)
		else $error("second general output does not follow carrier sense");

	strap_low_hiz_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && st.strap_done && !st.strap_clk && bidir_one_func == GPD_FN_DEFAULT |=>
		bidir_pin_one_oe_n && !st.clk_sel)
		else $error("pin one driven although strap was low");

	strap_high_clk_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && st.strap_done && st.strap_clk && bidir_one_func == GPD_FN_DEFAULT |=>
		!bidir_pin_one_oe_n && bidir_pin_one_o == clk_125_src)
		else $error("pin one not driving clock although strap was high");

	// Both functions must stand on the same edge, since every enabled edge after the strap sample reloads the enables
	pin_two_hiz_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && bidir_two_func == GPD_FN_DEFAULT &&
		bidir_three_func == GPD_FN_DEFAULT |=> bidir_pin_two_oe_n && bidir_pin_three_oe_n)
		else $error("default pins two or three driven");

	gmii_shared_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && gmii ##1 clk_en && gmii |=> st.bd_oe_n[6:3] == 4'hf &&
		txd_upper == $past(bidir_in_level[6:3]))
		else $error("shared pins misbehave in GMII mode");

	sw_override_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en && st.strap_done && second_out_func == GPD_FN_HIGH &&
		bidir_two_func == GPD_FN_LOW |=> second_general_output_o &&
		!second_general_output_oe_n && !bidir_pin_two_o && !bidir_pin_two_oe_n)
		else $error("software function not applied");

	strap_sample_a: assert property (@(posedge clk_sys) disable iff (rst)
		!st.strap_done |-> (first_general_output_oe_n && second_general_output_oe_n) and
		(clk_en |=> st.strap_done && st.strap_clk == $past(first_general_output_i)))
		else $error("strap not sampled while outputs undriven");

	reset_state_a: assert property (@(posedge clk_sys)
		rst |-> st == GPD_ST_RESET && bidir_pin_one_oe_n && !strap_clk_out)
		else $error("reset did not restore defaults");

	sync_two_a: assert property (@(posedge clk_sys) disable iff (rst)
		clk_en ##1 clk_en |=> bidir_in_level[0] == $past(bidir_pin_one_i, 2) &&
		gpo_in_level[1] == $past(second_general_output_i, 2))
		else $error("input level not delayed by two stages");
endmodule
`default_nettype wire

// [shared/gpd_pkg.sv]
// Purpose: Shared constants and types for the general-purpose pin block
// Assumes: clk_sys registers everything but the clk_125_src mux onto pin one; pin levels pass a two-stage synchroniser into clk_sys
// Notes: Function select codes are not visible to software through any bus
package gpd_pkg;
	localparam int GPD_NUM_GPO = 2;
	localparam int GPD_NUM_BIDIR = 7;
	localparam int GPD_NUM_PINS = GPD_NUM_GPO + GPD_NUM_BIDIR;
	// First bidirectional pin shared with upper transmit data, and how many share
	localparam int GPD_SHARED_LO = 3;
	localparam int GPD_SHARED_NUM = 4;
	// Bit position of bidirectional pin one in the synchroniser vectors
	localparam int GPD_SYNC_BIDIR_BASE = GPD_NUM_GPO;
	// Index of the two general outputs in the synchroniser vectors
	localparam int GPD_SYNC_GPO_FIRST = 0;
	localparam int GPD_SYNC_GPO_SECOND = 1;

	typedef enum logic [1:0] {
		GPD_FN_DEFAULT,
		GPD_FN_INPUT,
		GPD_FN_LOW,
		GPD_FN_HIGH
	} gpd_func_t;

	typedef enum logic [1:0] {
		GPD_PAR_GMII,
		GPD_PAR_MII,
		GPD_PAR_RGMII
	} gpd_par_t;

	typedef struct packed {
		logic strap_done;
		logic strap_clk;
		logic clk_sel;
		logic [GPD_NUM_PINS-1:0] sync_a;
		logic [GPD_NUM_PINS-1:0] sync_b;
		logic [GPD_NUM_GPO-1:0] gpo_o;
		logic [GPD_NUM_GPO-1:0] gpo_oe_n;
		logic [GPD_NUM_BIDIR-1:0] bd_o;
		logic [GPD_NUM_BIDIR-1:0] bd_oe_n;
		logic [GPD_SHARED_NUM-1:0] txd_hi;
	} gpd_state_t;

	localparam gpd_state_t GPD_ST_RESET = '{
		strap_done: 1'b0,
		strap_clk: 1'b0,
		clk_sel: 1'b0,
		sync_a: '0,
		sync_b: '0,
		gpo_o: '0,
		gpo_oe_n: '1,
		bd_o: '0,
		bd_oe_n: '1,
		txd_hi: '0
	};
endpackage

// [sim/general_purpose_pin_defaults_tb_top.sv]
// Purpose: Random and corner checks of pin defaults, strap and overrides
// Assumes: clk_en low only in the freeze case; pin index 0..1 general outputs, 2..8 bidir
// Notes: Undriven pin drive levels are not compared outside the freeze hold checks
`timescale 1ns/1ps
`default_nettype none
module general_purpose_pin_defaults_tb_top;
	import gpd_pkg::*;
	logic clk_sys = 0, rst = 0, en = 1, link_up = 0, carrier_sense = 0, clk_125_src = 0;
	logic strap = 0;
	logic [8:0] keep_o, keep_oe_n;
	gpd_par_t par_mode = GPD_PAR_MII;
	gpd_func_t fn [9] = '{default: GPD_FN_DEFAULT};
	logic [8:0] pull = '0, po, po_n, lvl;
	logic [1:0] gpo_in_level;
	logic [6:0] bidir_in_level;
	logic [3:0] txd_upper;
	logic strap_clk_out;
	int err_total = 0, n_tests = 0;
	initial forever #10 clk_sys = ~clk_sys;
	initial forever #4 clk_125_src = ~clk_125_src;
	gpd_board u_gpd_board (.drv_o(po), .drv_oe_n(po_n), .pull(pull), .lvl(lvl));
	gpd_pins u_gpd_pins (.clk_sys(clk_sys), .rst(rst), .clk_en(en), .link_up(link_up),
		.carrier_sense(carrier_sense), .clk_125_src(clk_125_src), .par_mode(par_mode),
		.first_out_func(fn[0]), .second_out_func(fn[1]), .bidir_one_func(fn[2]),
		.bidir_two_func(fn[3]), .bidir_three_func(fn[4]), .bidir_four_func(fn[5]),
		.bidir_five_func(fn[6]), .bidir_six_func(fn[7]), .bidir_seven_func(fn[8]),
		.first_general_output_i(lvl[0]), .first_general_output_o(po[0]),
		.first_general_output_oe_n(po_n[0]), .second_general_output_i(lvl[1]),
		.second_general_output_o(po[1]), .second_general_output_oe_n(po_n[1]),
		.bidir_pin_one_i(lvl[2]), .bidir_pin_one_o(po[2]), .bidir_pin_one_oe_n(po_n[2]),
		.bidir_pin_two_i(lvl[3]), .bidir_pin_two_o(po[3]), .bidir_pin_two_oe_n(po_n[3]),
		.bidir_pin_three_i(lvl[4]), .bidir_pin_three_o(po[4]), .bidir_pin_three_oe_n(po_n[4]),
		.bidir_pin_four_shared_i(lvl[5]), .bidir_pin_four_shared_o(po[5]),
		.bidir_pin_four_shared_oe_n(po_n[5]), .bidir_pin_five_shared_i(lvl[6]),
		.bidir_pin_five_shared_o(po[6]), .bidir_pin_five_shared_oe_n(po_n[6]),
		.bidir_pin_six_shared_i(lvl[7]), .bidir_pin_six_shared_o(po[7]),
		.bidir_pin_six_shared_oe_n(po_n[7]), .bidir_pin_seven_shared_i(lvl[8]),
		.bidir_pin_seven_shared_o(po[8]), .bidir_pin_seven_shared_oe_n(po_n[8]),
		.gpo_in_level(gpo_in_level), .bidir_in_level(bidir_in_level),
		.txd_upper(txd_upper), .strap_clk_out(strap_clk_out));

	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Returns {oe_n, o} for a function code given the pin's default drive
	function automatic logic [1:0] exp_pin(gpd_func_t f, logic d_oe_n, logic d_o);
		case (f)
			GPD_FN_DEFAULT: return {d_oe_n, d_o};
			GPD_FN_INPUT: return 2'b10;
			GPD_FN_LOW: return 2'b00;
			default: return 2'b01;
		endcase
	endfunction

	task automatic check_pins();
		logic [1:0] e;
		for (int i = 0; i < 9; i++) begin
			if (i == 0) e = exp_pin(fn[0], 1'b0, link_up);
			else if (i == 1) e = exp_pin(fn[1], 1'b0, carrier_sense);
			else if (i == 2) e = exp_pin(fn[2], !strap, clk_125_src);
			else if (i >= 5 && par_mode == GPD_PAR_GMII) e = 2'b10;
			else e = exp_pin(fn[i], 1'b1, 1'b0);
			chk($sformatf("oe_n%0d", i), 8'(po_n[i]), 8'(e[1]));
			if (!e[1]) chk($sformatf("o%0d", i), 8'(po[i]), 8'(e[0]));
		end
	endtask

	task automatic check_levels();
		logic [6:0] m;
		m = (fn[2] == GPD_FN_DEFAULT && strap) ? 7'h7e : 7'h7f;
		chk("gpo_lvl", 8'(gpo_in_level), 8'(lvl[1:0]));
		chk("bd_lvl", 8'(bidir_in_level & m), 8'(lvl[8:2] & m));
		chk("txd", 8'(txd_upper), par_mode == GPD_PAR_GMII ? 8'(lvl[8:5]) : 8'h00);
	endtask

	// Strap is only seen through the first pull while the device leaves the pin idle
	task automatic do_reset(logic s);
		@(posedge clk_sys);
		rst <= 1'b1;
		strap <= s;
		pull <= {8'h00, s};
		fn <= '{default: GPD_FN_DEFAULT};
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("strap", 8'(strap_clk_out), 8'(s));
		check_pins();
		if (!s) chk("one_oe_n", 8'(po_n[2]), 8'h01);
	endtask

	// Frozen block must ignore new functions and inputs until enabled again
	task automatic check_freeze();
		keep_o = po;
		keep_oe_n = po_n;
		@(posedge clk_sys);
		en <= 1'b0;
		for (int i = 1; i < 9; i++) fn[i] <= gpd_func_t'($urandom_range(3));
		fn[0] <= GPD_FN_DEFAULT;
		link_up <= ~link_up;
		carrier_sense <= ~carrier_sense;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("hold_oe_n", 8'(po_n[8:1]), 8'(keep_oe_n[8:1]));
		chk("hold_oe_n0", 8'(po_n[0]), 8'(keep_oe_n[0]));
		chk("hold_o", 8'(po[8:1] & 8'hfd), 8'(keep_o[8:1] & 8'hfd));
		chk("hold_o0", 8'(po[0]), 8'(keep_o[0]));
		chk("hold_strap", 8'(strap_clk_out), 8'(strap));
		@(posedge clk_sys);
		en <= 1'b1;
		@(posedge clk_sys);
		#1;
		check_pins();
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		rst <= 1'b1;
		void'($urandom(32'hd05c));
		do_reset(1'b1);
		do_reset(1'b0);
		do_reset(1'b1);
		for (int k = 0; k < 60; k++) begin
			@(posedge clk_sys);
			for (int i = 0; i < 9; i++) fn[i] <= gpd_func_t'(k < 4 ? k : $urandom_range(3));
			par_mode <= gpd_par_t'(k < 6 ? k % 3 : $urandom_range(2));
			link_up <= 1'($urandom);
			carrier_sense <= 1'($urandom);
			pull <= 9'($urandom);
			@(posedge clk_sys);
			#1;
			check_pins();
			repeat (3) @(posedge clk_sys);
			#1;
			check_levels();
		end
		check_freeze();
		finish_test();
	end
endmodule
`default_nettype wire

// [sim/gpd_board.sv]
// Purpose: Board around the general pins: resistors that set each idle level
// Assumes: Every pin carries a pull resistor whose level the bench picks
// Notes: The first pull doubles as the reset strap
`timescale 1ns/1ps
`default_nettype none
module gpd_board (
	input wire logic [8:0] drv_o,
	input wire logic [8:0] drv_oe_n,
	input wire logic [8:0] pull,
	output logic [8:0] lvl
);
	// A released pin falls back to its resistor, never the last driven value
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			lvl[i] = drv_oe_n[i] ? pull[i] : drv_o[i];
		end
	end
endmodule
`default_nettype wire
